/* iopig_top.sv */
`timescale 1ns/1ps
`include "iopig_regs.svh"
module iopig_top
    import iopig_pkg::*;
#(
    parameter int NSLOT = `IOPIG_NSLOT
)
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Vector requests from board logic
    input  wire iopig_vec_cfg_t   vec0_cfg,
    input  wire iopig_vec_cfg_t   vec1_cfg,
    output logic                  vec0_granted,
    output logic                  vec1_granted,
    // Backplane request lines, open drain, bit0 = line 4
    input  wire logic [3:0]       irq_in,
    output logic [3:0]            irq_out,
    output logic [3:0]            irq_oe,
    // Grant daisy chain
    input  wire logic             gnt_in,
    output logic                  gnt_out,
    // Slot grant settings, bit set = pass; strap overrides default
    input  wire logic [NSLOT-1:0] slot_pass_strap,
    input  wire logic             slot_strap_use,
    input  wire logic [2:0]       slot_sel,
    // Board identity
    input  wire logic             addr_second,
    input  wire logic             second_present,
    output logic                  io_processor_board_second
);
    logic [3:0]       irq_s1_r, irq_s2_r;
    logic             gnt_s1_r, gnt_s2_r;
    logic [NSLOT-1:0] strap_s1_r, strap_s2_r;
    logic             use_s1_r, use_s2_r;
    logic [2:0]       sel_s1_r, sel_s2_r;
    logic             addr_s1_r, addr_s2_r;
    logic             pres_s1_r, pres_s2_r;
    logic [NSLOT-1:0] pass_map;
    logic             slot_pass;
    logic             board_gnt;
    logic             g0_out, g1_out;
    logic [3:0]       d0, d1;
    logic             id_r, id_nxt;
    logic             gout_r, gout_nxt;

    // Two-stage sync of backplane inputs
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            irq_s1_r <= 4'h0;
            irq_s2_r <= 4'h0;
            gnt_s1_r <= 1'b0;
            gnt_s2_r <= 1'b0;
        end
        else
        begin
            irq_s1_r <= irq_in;
            irq_s2_r <= irq_s1_r;
            gnt_s1_r <= gnt_in;
            gnt_s2_r <= gnt_s1_r;
        end
    end

    // Strap pins: static, but a jumper move must not glitch the chain
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            strap_s1_r <= '0;
            strap_s2_r <= '0;
            use_s1_r   <= 1'b0;
            use_s2_r   <= 1'b0;
            sel_s1_r   <= 3'h0;
            sel_s2_r   <= 3'h0;
            addr_s1_r  <= 1'b0;
            addr_s2_r  <= 1'b0;
            pres_s1_r  <= 1'b0;
            pres_s2_r  <= 1'b0;
        end
        else
        begin
            strap_s1_r <= slot_pass_strap;
            strap_s2_r <= strap_s1_r;
            use_s1_r   <= slot_strap_use;
            use_s2_r   <= use_s1_r;
            sel_s1_r   <= slot_sel;
            sel_s2_r   <= sel_s1_r;
            addr_s1_r  <= addr_second;
            addr_s2_r  <= addr_s1_r;
            pres_s1_r  <= second_present;
            pres_s2_r  <= pres_s1_r;
        end
    end

    // Defaults: empty and memory slots pass
    assign pass_map  = use_s2_r ? strap_s2_r
                     : NSLOT'(`IOPIG_SLOT_PASS_DFLT); // R09
    assign slot_pass = (int'(sel_s2_r) < NSLOT) ? pass_map[sel_s2_r] : 1'b1;
    assign board_gnt = slot_pass ? 1'b0 : gnt_s2_r; // R08

    // Two independent circuits, vector 0 nearer the grant
    iopig_vector u_vec0 ( // R01
        .clock     (clock),
        .rst       (rst),
        .cfg       (vec0_cfg),
        .granted   (vec0_granted),
        .irq_sync  (irq_s2_r),
        .gnt_in    (board_gnt),
        .gnt_out   (g0_out),
        .irq_drive (d0)
    );
    iopig_vector u_vec1 ( // R01
        .clock     (clock),
        .rst       (rst),
        .cfg       (vec1_cfg),
        .granted   (vec1_granted),
        .irq_sync  (irq_s2_r),
        .gnt_in    (g0_out),
        .gnt_out   (g1_out),
        .irq_drive (d1)
    );

    // Open drain: drive low-active line by enable only
    assign irq_out = 4'h0;
    assign irq_oe  = d0 | d1; // R02

    // Next grant out and identity
    always_comb
    begin
        gout_nxt = slot_pass ? gnt_s2_r : g1_out; // R07 R08
        id_nxt   = addr_s2_r && pres_s2_r; // R10
    end

    // Registered grant and identity; lone board is first
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            gout_r <= 1'b0;
            id_r   <= 1'b0;
        end
        else
        begin
            gout_r <= gout_nxt;
            id_r   <= id_nxt;
        end
    end

    assign gnt_out                   = gout_r;
    assign io_processor_board_second = id_r;

    property p_pass;
        @(posedge clock) disable iff (rst)
        slot_pass |=> gnt_out == $past(gnt_s2_r);
    endproperty
    a_pass: assert property (p_pass) // R07
        else $error("pass mode altered grant");

    property p_lone;
        @(posedge clock) disable iff (rst)
        !pres_s2_r |=> !io_processor_board_second;
    endproperty
    a_lone: assert property (p_lone) // R10
        else $error("lone board not first");

    property p_nopass_kept;
        @(posedge clock) disable iff (rst)
        !slot_pass && (vec0_granted || vec1_granted) |=> !gnt_out;
    endproperty
    a_nopass_kept: assert property (p_nopass_kept) // R08
        else $error("kept grant forwarded");

    // No-pass slot with nothing pending hands the grant on
    property p_nopass_fwd;
        @(posedge clock) disable iff (rst)
        !slot_pass && gnt_s2_r && !vec0_cfg.req && !vec1_cfg.req
            && !vec0_granted && !vec1_granted |=> gnt_out;
    endproperty
    a_nopass_fwd: assert property (p_nopass_fwd) // R08
        else $error("idle board swallowed the grant");

    // Only one circuit may own the grant at a time
    property p_one_owner;
        @(posedge clock) disable iff (rst)
        !(vec0_granted && vec1_granted);
    endproperty
    a_one_owner: assert property (p_one_owner) // R06
        else $error("both vectors hold the grant");

    // Line 7 belongs to the host; this board never pulls it
    property p_oe_no_l7;
        @(posedge clock) disable iff (rst)
        !irq_oe[`IOPIG_LINE7];
    endproperty
    a_oe_no_l7: assert property (p_oe_no_l7) // R05
        else $error("line 7 pulled");

    // No request pending, no line pulled
    property p_oe_idle;
        @(posedge clock) disable iff (rst)
        !vec0_cfg.req && !vec1_cfg.req |-> irq_oe == 4'h0;
    endproperty
    a_oe_idle: assert property (p_oe_idle) // R02
        else $error("line pulled with no request");

    // Pass mode keeps the grant away from both circuits
    property p_pass_bypass;
        @(posedge clock) disable iff (rst)
        slot_pass && !vec0_granted && !vec1_granted
            |=> !(vec0_granted || vec1_granted);
    endproperty
    a_pass_bypass: assert property (p_pass_bypass) // R07
        else $error("circuit took a passed grant");

    // Slot 0 carries a requesting board: no-pass by default
    property p_dflt_slot0;
        @(posedge clock) disable iff (rst)
        !use_s2_r && sel_s2_r == 3'h0 |-> !slot_pass;
    endproperty
    a_dflt_slot0: assert property (p_dflt_slot0) // R09
        else $error("default slot 0 passes the grant");

    // First identity whenever the address setting says first
    property p_addr_first;
        @(posedge clock) disable iff (rst)
        !addr_s2_r |=> !io_processor_board_second;
    endproperty
    a_addr_first: assert property (p_addr_first) // R10
        else $error("second identity without second address");

    c_pass: cover property (@(posedge clock) disable iff (rst)
        slot_pass && gnt_s2_r);
    c_g1: cover property (@(posedge clock) disable iff (rst) vec1_granted);
    c_sec: cover property (@(posedge clock) disable iff (rst)
        io_processor_board_second);
    c_fwd: cover property (@(posedge clock) disable iff (rst)
        !slot_pass && gnt_out);
endmodule

/* iopig_regs.svh */
// Function
// R01: Board has two vector circuits, each with its own independent level.
// R02: A setting picks the request lines a circuit drives when requesting.
// R03: A setting picks the higher lines watched before taking a grant.
// R04: Drive/watch: L4 4/5,6; L5 4,5/6; L6 4,6/7.
// R05: Level 7 can never be selected; it belongs to the host.
// R06: Grant taken only with a pending request and no watched line asserted.
// R07: Slot in pass mode forwards the grant unchanged down the chain.
// R08: Slot in no-pass mode routes the grant through its board.
// R09: Empty and memory slots default to pass; all others to no-pass.
// R10: Board identity follows its address setting; a lone board is first.
`ifndef IOPIG_REGS_SVH
`define IOPIG_REGS_SVH

// Request line bit positions within the 4-bit vector for levels 4..7
`define IOPIG_LINE4 0
`define IOPIG_LINE5 1
`define IOPIG_LINE6 2
`define IOPIG_LINE7 3

// Drive and watch masks per level, bit0 = line 4
`define IOPIG_DRV_L4 4'h1
`define IOPIG_WCH_L4 4'h6
`define IOPIG_DRV_L5 4'h3
`define IOPIG_WCH_L5 4'h4
`define IOPIG_DRV_L6 4'h5
`define IOPIG_WCH_L6 4'h8

// Number of slots with grant settings; defaults, bit set = pass
`define IOPIG_NSLOT 7
`define IOPIG_SLOT_PASS_DFLT 7'h3E

`endif

/* iopig_pkg.sv */
package iopig_pkg;
    // Selectable levels only; level 7 has no encoding
    typedef enum logic [1:0] {
        IOPIG_LVL4 = 2'h0,
        IOPIG_LVL5 = 2'h1,
        IOPIG_LVL6 = 2'h2
    } iopig_level_t;

    // Per-vector request interface
    typedef struct packed {
        logic         req;
        iopig_level_t lvl;
    } iopig_vec_cfg_t;
endpackage

/* iopig_vector.sv */
`timescale 1ns/1ps
`include "iopig_regs.svh"
module iopig_vector
    import iopig_pkg::*;
(
    // Clock and reset
    input  wire logic           clock,
    input  wire logic           rst,
    // User side
    input  wire iopig_vec_cfg_t cfg,
    output logic                granted,
    // Chain side, synchronised request lines and grant
    input  wire logic [3:0]     irq_sync,
    input  wire logic           gnt_in,
    output logic                gnt_out,
    output logic [3:0]          irq_drive
);
    typedef enum {VS_IDLE, VS_HOLD} iopig_vst_t;
    iopig_vst_t  st_r, st_nxt;
    logic [3:0]  watch;
    logic        take;
    logic        legal;

    // Level decode; illegal code drives nothing
    always_comb
    begin
        legal = 1'b1;
        unique case (cfg.lvl)
            IOPIG_LVL4:
            begin
                irq_drive = `IOPIG_DRV_L4; // R02 R04
                watch     = `IOPIG_WCH_L4; // R03 R04
            end
            IOPIG_LVL5:
            begin
                irq_drive = `IOPIG_DRV_L5; // R04
                watch     = `IOPIG_WCH_L5; // R04
            end
            IOPIG_LVL6:
            begin
                irq_drive = `IOPIG_DRV_L6; // R04
                watch     = `IOPIG_WCH_L6; // R04
            end
            default:
            begin
                irq_drive = 4'h0; // R05 no level 7
                watch     = 4'hF;
                legal     = 1'b0; // R05
            end
        endcase
        if (!cfg.req)
        begin
            irq_drive = 4'h0;
        end
    end

    // Capture only if pending and no watched higher line active
    // Illegal code must never take, even with every line quiet
    assign take    = gnt_in && cfg.req && legal
                     && ((irq_sync & watch) == 4'h0); // R06
    assign gnt_out = gnt_in && !take && (st_r == VS_IDLE); // R06

    // Hold grant until the grant drops
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            VS_IDLE: if (take) st_nxt = VS_HOLD;
            VS_HOLD: if (!gnt_in) st_nxt = VS_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st_r <= VS_IDLE;
        else
            st_r <= st_nxt;
    end

    assign granted = (st_r == VS_HOLD);

    property p_no_l7;
        @(posedge clock) disable iff (rst)
        !irq_drive[`IOPIG_LINE7];
    endproperty
    a_no_l7: assert property (p_no_l7) else $error("line 7 driven"); // R05

    property p_take_blocks;
        @(posedge clock) disable iff (rst)
        (gnt_in && st_r == VS_IDLE && cfg.req && (irq_sync & watch) != 4'h0)
            |-> gnt_out;
    endproperty
    a_take_blocks: assert property (p_take_blocks) // R06
        else $error("grant kept despite higher line");

    property p_hold;
        @(posedge clock) disable iff (rst)
        take && st_r == VS_IDLE |=> granted;
    endproperty
    a_hold: assert property (p_hold) else $error("grant not held"); // R06

    property p_l4;
        @(posedge clock) disable iff (rst)
        cfg.req && cfg.lvl == IOPIG_LVL4 |-> irq_drive == 4'h1;
    endproperty
    a_l4: assert property (p_l4) else $error("level 4 lines wrong"); // R04

    property p_l6;
        @(posedge clock) disable iff (rst)
        cfg.req && cfg.lvl == IOPIG_LVL6 |-> irq_drive == 4'h5;
    endproperty
    a_l6: assert property (p_l6) else $error("level 6 lines wrong"); // R04

    c_take: cover property (@(posedge clock) disable iff (rst) take);
endmodule

/* iopig_host_model.sv */
`timescale 1ns/1ps
module iopig_host_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Bench control: ask for a grant, with a stall in cycles
    input  wire logic       go,
    input  wire logic [1:0] dly,
    // Grant into the chain
    output logic            gnt_in
);
    logic [1:0] wait_r;

    // Slow or prompt host; grant held until the ask drops
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst || !go)
        begin
            gnt_in <= 1'b0;
            wait_r <= 2'h0;
        end
        else if (wait_r == dly)
            gnt_in <= 1'b1;
        else
            wait_r <= wait_r + 2'h1;
    end
endmodule

/* iop_interrupt_priority_grant_tb.sv */
`timescale 1ns/1ps
`include "iopig_regs.svh"
module iop_interrupt_priority_grant_tb;
    import iopig_pkg::*;
    logic clock = 0, rst = 1, go = 0, a2 = 0, sp = 0, use_s = 0;
    logic gnt_in, gnt_out, g0, g1, sec_id, ps;
    logic [3:0] other = '0, irq_out, irq_oe, irq_in;
    logic [6:0] strap = '0;
    logic [2:0] sel = '0;
    logic [1:0] dly = '0;
    logic [2:0] eg;
    logic [6:0] dflt = `IOPIG_SLOT_PASS_DFLT;
    iopig_vec_cfg_t c0 = '0, c1 = '0;
    int bad_count = 0, checks = 0, n;

    always #5 clock = ~clock;
    // Open-drain lines: other boards plus our own enables
    assign irq_in = other | irq_oe;

    iopig_top i_dut (.clock(clock), .rst(rst), .vec0_cfg(c0), .vec1_cfg(c1),
        .vec0_granted(g0), .vec1_granted(g1), .irq_in(irq_in),
        .irq_out(irq_out), .irq_oe(irq_oe), .gnt_in(gnt_in),
        .gnt_out(gnt_out), .slot_pass_strap(strap), .slot_strap_use(use_s),
        .slot_sel(sel), .addr_second(a2), .second_present(sp),
        .io_processor_board_second(sec_id));
    iopig_host_model i_host (.clock(clock), .rst(rst), .go(go), .dly(dly),
        .gnt_in(gnt_in));

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task summarize;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Lines pulled per level; level 7 code drives nothing
    function logic [3:0] drv(iopig_vec_cfg_t c);
        if (!c.req || c.lvl == 2'h3)
            return 4'h0;
        return (c.lvl == 2'h0) ? 4'h1 : (c.lvl == 2'h1) ? 4'h3 : 4'h5;
    endfunction

    // Capture allowed: pending, legal level, no watched line up
    function logic ok(iopig_vec_cfg_t c, logic [3:0] w);
        logic [3:0] m;
        m = (c.lvl == 2'h0) ? 4'h6 : (c.lvl == 2'h1) ? 4'h4 : 4'h8;
        return c.req && c.lvl != 2'h3 && (w & m) == 4'h0;
    endfunction

    initial
    begin
        void'($urandom(54336));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 60; i++)
        begin
            // First four rounds walk every level code on vector 0, later ones random
            @(posedge clock);
            c0 <= '{req: ($urandom % 4 != 0), lvl: iopig_level_t'(i < 4 ?
                   i % 4 : $urandom % 3)};
            c1 <= '{req: 1'($urandom), lvl: iopig_level_t'($urandom % 3)};
            other <= ($urandom % 2) ? 4'h0 : 4'($urandom);
            sel <= 3'($urandom);
            use_s <= 1'($urandom);
            strap <= 7'($urandom);
            a2 <= 1'($urandom);
            sp <= 1'($urandom);
            dly <= 2'($urandom);
            repeat (3) @(posedge clock);
            #1;
            chk({irq_out, irq_oe}, {4'h0, drv(c0) | drv(c1)});
            chk(sec_id, a2 & sp);
            ps = (sel == 3'h7) ? 1'b1 : (use_s ? strap[sel] : dflt[sel]);
            @(posedge clock);
            go <= 1'b1;
            n = 0;
            while (n < 12 && !(gnt_out | g0 | g1))
            begin
                @(posedge clock);
                #1;
                n++;
            end
            // A grant that never shows counts once and ends the run
            if (n == 12)
            begin
                $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
                bad_count++;
                break;
            end
            eg = ps ? 3'h1 : ok(c0, irq_in) ? 3'h4 :
                 ok(c1, irq_in) ? 3'h2 : 3'h1;
            chk({g0, g1, gnt_out}, eg);
            // Mid-run reset while a grant is held
            if (i == 30)
            begin
                @(posedge clock);
                rst <= 1'b1;
                @(posedge clock);
                #1;
                chk({g0, g1, gnt_out, sec_id}, 8'h0);
                @(posedge clock);
                rst <= 1'b0;
            end
            @(posedge clock);
            go <= 1'b0;
            repeat (6) @(posedge clock);
            #1;
            chk({g0, g1, gnt_out}, 8'h0);
        end
        summarize();
    end
endmodule
